// ===== hw/mcd_agu.sv
// pointer post-modification and reverse write-back address
`timescale 1ns/10ps
`include "mcd_params.svh"
module mcd_agu (
    // pointer and selected offset
    input  wire logic              [15:0] ptr_i,
    input  wire logic              [15:0] off_i,
    input  wire mcd_pkg::mcd_pmod_t       mode_i,
    // results
    output logic                   [15:0] next_ptr_o,
    output logic                   [15:0] back_addr_o
);
    import mcd_pkg::*;

    // ==========================================================
    // forward and inverse modification
    always_comb begin
        case (mode_i)
            MCD_PM_INC: begin
                next_ptr_o  = ptr_i + `MCD_PTR_STEP;
                back_addr_o = ptr_i - `MCD_PTR_STEP;
            end
            MCD_PM_DEC: begin
                next_ptr_o  = ptr_i - `MCD_PTR_STEP;
                back_addr_o = ptr_i + `MCD_PTR_STEP;
            end
            MCD_PM_ADDQ: begin
                next_ptr_o  = ptr_i + off_i;
                back_addr_o = ptr_i - off_i;
            end
            MCD_PM_SUBQ: begin
                next_ptr_o  = ptr_i - off_i;
                back_addr_o = ptr_i + off_i;
            end
            default: begin // keep: move lands on the pointer itself
                next_ptr_o  = ptr_i;
                back_addr_o = ptr_i;
            end
        endcase
    end
endmodule : mcd_agu

// ===== hw/mcd_datapath.sv
// multiply-accumulate coprocessor datapath: address generation, multiplier, adder, flags
`timescale 1ns/10ps
`include "mcd_params.svh"
// Contract
// - three stages, acc and flags at execute end
// - decode computes addresses; gpr written at execute
// - write-back stage stores the parallel move
// - double indirect: gpr plus table pointer
// - table pointer confined to dual-port ram except on copy; the parallel move address is not folded into it
// - table pointer keep, step two, offset
// - sixteen gpr pointers, five modification kinds
// - parallel move only for mac-with-move
// - move address inverts the modification
// - signed/unsigned 16x16 product, sign-extended
// - fraction shift drops the redundant sign
// - extension flag marks bits above 32
// - adder A: zero, round, product, concatenation
// - adder B: zero or modified accumulator
// - saturation loads extreme 32-bit values
// - saturation sets sticky saturated flag
// - 40-bit overflow sets sticky overflow flag
// - accumulator is high, low, extension byte
// - limited read substitutes 7FFF or 8000
// - limited read changes no state
// - rounding adds bit 15, clears low word
// - unsigned operands only for multiplies
module mcd_datapath #(
    parameter int ADDR_W = 24
) (
    // clock and reset
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_i,
    // instruction in decode stage
    input  wire logic                   dec_valid_i,
    input  wire logic                   mac_with_move_insn_i,
    input  wire logic                   coproc_copy_insn_i,
    input  wire logic                   dec_tbl_sel_i,
    input  wire mcd_pkg::mcd_pmod_t     dec_tbl_mod_i,
    input  wire logic                   dec_tbl_off_sel_i,
    input  wire logic            [3:0]  dec_gpr_idx_i,
    input  wire logic           [15:0]  dec_gpr_ptr_i,
    input  wire mcd_pkg::mcd_pmod_t     dec_gpr_mod_i,
    input  wire logic                   dec_gpr_off_sel_i,
    input  wire logic                   dec_wr_acc_i,
    input  wire mcd_pkg::mcd_asel_t     dec_asel_i,
    input  wire logic                   dec_b_acc_i,
    input  wire logic                   dec_b_inv_i,
    input  wire logic                   dec_b_shl_i,
    input  wire logic                   dec_cat_shl_i,
    input  wire logic                   dec_round_i,
    input  wire logic                   dec_signed_a_i,
    input  wire logic                   dec_signed_b_i,
    // operand fetch
    input  wire logic [ADDR_W-17:0]     data_page_i,
    output logic      [ADDR_W-1:0]      tbl_addr_o,
    output logic      [ADDR_W-1:0]      gpr_addr_o,
    input  wire logic           [15:0]  operand_bus_a_i,
    input  wire logic           [15:0]  operand_bus_b_i,
    // pointer and offset register writes
    input  wire logic                   sfr_we_i,
    input  wire mcd_pkg::mcd_sfr_t      sfr_sel_i,
    input  wire logic           [15:0]  sfr_wdata_i,
    // control bits
    input  wire logic                   fraction_shift_enable_i,
    input  wire logic                   saturate_enable_i,
    input  wire logic                   clr_sticky_overflow_i,
    input  wire logic                   clr_saturated_i,
    // gpr pointer write-back
    output logic                        gpr_wr_en_o,
    output logic                 [3:0]  gpr_wr_idx_o,
    output logic                [15:0]  gpr_wr_data_o,
    // parallel move write
    output logic                        move_wr_en_o,
    output logic      [ADDR_W-1:0]      move_addr_o,
    output logic                [15:0]  move_data_o,
    // accumulator and status
    output logic                [15:0]  acc_high_word_o,
    output logic                [15:0]  acc_low_word_o,
    output logic                 [7:0]  acc_ext_byte_o,
    output logic                [15:0]  mac_status_word_o,
    output logic                        ext_flag_o,
    output logic                        sticky_overflow_flag_o,
    output logic                        saturated_flag_o,
    output logic                [15:0]  limited_acc_read_o,
    output logic                [15:0]  table_pointer_a_o,
    output logic                [15:0]  table_pointer_b_o
);
    import mcd_pkg::*;

    // refused at elaboration: the page field needs at least one bit
    if (ADDR_W < 17 || ADDR_W > 32) begin : g_bad_addr_w
        $error("mcd_datapath: ADDR_W must be 17..32");
    end

    mcd_state_t st;
    mcd_state_t next_st;

    logic [15:0] cur_tbl_ptr;
    logic [15:0] tbl_next;
    logic [15:0] tbl_back;
    logic [15:0] gpr_next;
    logic        tbl_in_ram;
    logic [15:0] tbl_eff;

    // ==========================================================
    // address generation (decode stage)
    assign cur_tbl_ptr = st.tbl_ptr[dec_tbl_sel_i];

    mcd_agu u_tbl_agu (
        .ptr_i       (cur_tbl_ptr),
        .off_i       (st.tbl_off[dec_tbl_off_sel_i]),
        .mode_i      (dec_tbl_mod_i),
        .next_ptr_o  (tbl_next),
        .back_addr_o (tbl_back)
    );

    mcd_agu u_gpr_agu (
        .ptr_i       (dec_gpr_ptr_i),
        .off_i       (st.gpr_off[dec_gpr_off_sel_i]),
        .mode_i      (dec_gpr_mod_i),
        .next_ptr_o  (gpr_next),
        .back_addr_o ()
    );

    // out-of-window table pointers fold back into the ram, copy reaches anywhere
    assign tbl_in_ram = (cur_tbl_ptr >= `MCD_DPRAM_BASE) && (cur_tbl_ptr <= `MCD_DPRAM_LAST);
    assign tbl_eff    = (tbl_in_ram || coproc_copy_insn_i) ? cur_tbl_ptr
                      : `MCD_DPRAM_BASE + {6'h00, cur_tbl_ptr[`MCD_DPRAM_AW-1:0]};
    assign tbl_addr_o = {{(ADDR_W-16){1'b0}}, tbl_eff};
    assign gpr_addr_o = {data_page_i, dec_gpr_ptr_i};

    // ==========================================================
    // multiplier, scaler and adder (execute stage)
    logic signed [33:0] prod34;
    logic        [39:0] prod40;
    logic        [39:0] prod_sc;
    logic        [39:0] cat40;
    logic        [39:0] a_in;
    logic        [39:0] b_acc;
    logic        [39:0] b_in;
    logic        [39:0] sum;
    logic               ovf40;
    logic               ovf32;
    logic               neg_dir;
    logic               sat;
    logic        [39:0] acc_new;
    logic               ext_new;

    // signedness only affects the multiplier; concat is always two's complement
    assign prod34  = $signed({st.e_sa & st.e_opa[15], st.e_opa})
                   * $signed({st.e_sb & st.e_opb[15], st.e_opb});
    assign prod40  = {{6{prod34[33]}}, prod34};
    assign prod_sc = fraction_shift_enable_i ? {prod40[38:0], 1'b0} : prod40;
    assign cat40   = st.e_cat_shl ? {{7{st.e_opa[15]}}, st.e_opa, st.e_opb, 1'b0}
                                  : {{8{st.e_opa[15]}}, st.e_opa, st.e_opb};

    // A input source
    always_comb begin
        case (st.e_asel)
            MCD_A_ROUND: a_in = `MCD_ROUND_CONST;
            MCD_A_PROD:  a_in = prod_sc;
            MCD_A_CAT:   a_in = cat40;
            default:     a_in = `MCD_ACC_RESET;
        endcase
    end

    // B input: invert plus carry-in gives a true negation for subtraction
    assign b_acc = st.e_b_shl ? {st.acc[38:0], 1'b0} : st.acc;
    assign b_in  = st.e_b_acc ? (st.e_b_inv ? ~b_acc : b_acc)
                              : (st.e_b_inv ? ~`MCD_ACC_RESET : `MCD_ACC_RESET);
    assign sum   = a_in + b_in + {39'h0, st.e_b_inv};

    // overflow detection at the 40 and 32 bit boundaries
    assign ovf40   = (a_in[`MCD_ACC_MSB] == b_in[`MCD_ACC_MSB])
                   && (sum[`MCD_ACC_MSB] != a_in[`MCD_ACC_MSB]);
    assign ovf32   = ovf40 || !((&sum[`MCD_ACC_MSB:`MCD_SAT_LSB])
                   || !(|sum[`MCD_ACC_MSB:`MCD_SAT_LSB]));
    assign neg_dir = ovf40 ? ~sum[`MCD_ACC_MSB] : sum[`MCD_ACC_MSB];
    assign sat     = saturate_enable_i && ovf32;

    // saturation substitute, else the sum is kept with the low word cleared on round
    always_comb begin
        if (sat) begin
            acc_new = neg_dir ? `MCD_SAT_NEG : `MCD_SAT_POS;
        end else begin
            acc_new = sum;
            if (st.e_round) begin
                acc_new[15:0] = 16'h0000;
            end
        end
    end
    assign ext_new = !((&acc_new[`MCD_ACC_MSB:`MCD_SAT_LSB])
                   || !(|acc_new[`MCD_ACC_MSB:`MCD_SAT_LSB]));

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;
        // decode: latch operands, post-modify the table pointer
        next_st.e_valid     = dec_valid_i;
        next_st.e_wr_acc    = dec_valid_i && dec_wr_acc_i;
        next_st.e_asel      = dec_asel_i;
        next_st.e_b_acc     = dec_b_acc_i;
        next_st.e_b_inv     = dec_b_inv_i;
        next_st.e_b_shl     = dec_b_shl_i;
        next_st.e_cat_shl   = dec_cat_shl_i;
        next_st.e_round     = dec_round_i;
        next_st.e_sa        = dec_signed_a_i;
        next_st.e_sb        = dec_signed_b_i;
        next_st.e_opa       = operand_bus_a_i;
        next_st.e_opb       = operand_bus_b_i;
        next_st.e_gpr_we    = dec_valid_i && (dec_gpr_mod_i != MCD_PM_KEEP);
        next_st.e_gpr_idx   = dec_gpr_idx_i;
        next_st.e_gpr_val   = gpr_next;
        next_st.e_move      = dec_valid_i && mac_with_move_insn_i;
        next_st.e_move_addr = tbl_back;
        if (dec_valid_i) begin
            next_st.tbl_ptr[dec_tbl_sel_i] = tbl_next;
        end
        // execute: result and flags at the end of the cycle
        next_st.w_move      = st.e_move;
        next_st.w_move_addr = st.e_move_addr;
        next_st.w_move_data = st.e_opa;
        next_st.sv          = st.sv && !clr_sticky_overflow_i;
        next_st.sl          = st.sl && !clr_saturated_i;
        if (st.e_valid && st.e_wr_acc) begin
            next_st.acc = acc_new;
            next_st.ext = ext_new;
            if (ovf40) begin
                next_st.sv = 1'b1;
            end
            if (sat) begin
                next_st.sl = 1'b1;
            end
        end
        // software write lands last and overrides a same-cycle modification
        if (sfr_we_i) begin
            case (sfr_sel_i)
                MCD_SFR_TPA: next_st.tbl_ptr[0] = sfr_wdata_i;
                MCD_SFR_TPB: next_st.tbl_ptr[1] = sfr_wdata_i;
                MCD_SFR_TOA: next_st.tbl_off[0] = sfr_wdata_i;
                MCD_SFR_TOB: next_st.tbl_off[1] = sfr_wdata_i;
                MCD_SFR_GOA: next_st.gpr_off[0] = sfr_wdata_i;
                MCD_SFR_GOB: next_st.gpr_off[1] = sfr_wdata_i;
                default:     next_st.tbl_off[0] = st.tbl_off[0];
            endcase
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st        <= '0;
            st.e_asel <= MCD_A_ZERO;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    assign gpr_wr_en_o   = st.e_valid && st.e_gpr_we;
    assign gpr_wr_idx_o  = st.e_gpr_idx;
    assign gpr_wr_data_o = st.e_gpr_val;
    assign move_wr_en_o  = st.w_move;
    assign move_addr_o   = {{(ADDR_W-16){1'b0}}, st.w_move_addr};
    assign move_data_o   = st.w_move_data;
    // readable right after execute; spacing of other reads is software's job
    assign acc_high_word_o = st.acc[31:16];
    assign acc_low_word_o  = st.acc[15:0];
    assign acc_ext_byte_o  = st.acc[`MCD_ACC_MSB:32];
    always_comb begin
        mac_status_word_o              = {8'h00, st.acc[`MCD_ACC_MSB:32]};
        mac_status_word_o[`MCD_MSW_E]  = st.ext;
        mac_status_word_o[`MCD_MSW_SV] = st.sv;
        mac_status_word_o[`MCD_MSW_SL] = st.sl;
    end
    assign ext_flag_o             = st.ext;
    assign sticky_overflow_flag_o = st.sv;
    assign saturated_flag_o       = st.sl;
    // limiter is a pure view of the state, so a read disturbs nothing
    assign limited_acc_read_o = !st.ext ? st.acc[31:16]
                              : (st.acc[`MCD_ACC_MSB] ? `MCD_LIM_NEG : `MCD_LIM_POS);
    assign table_pointer_a_o  = st.tbl_ptr[0];
    assign table_pointer_b_o  = st.tbl_ptr[1];

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    chk_pipe_latency: assert property (dec_valid_i && dec_wr_acc_i && dec_asel_i == MCD_A_ZERO
        && !dec_b_acc_i && !dec_b_inv_i |-> ##2 st.acc == `MCD_ACC_RESET)
        else $error("accumulator not cleared two cycles after decode");
    chk_gpr_writeback: assert property (dec_valid_i && dec_gpr_mod_i == MCD_PM_INC
        |=> gpr_wr_en_o && gpr_wr_data_o == $past(dec_gpr_ptr_i) + `MCD_PTR_STEP)
        else $error("gpr pointer not written back in execute");
    chk_move_addr: assert property (dec_valid_i && mac_with_move_insn_i
        && dec_tbl_mod_i == MCD_PM_INC |-> ##2 move_wr_en_o
        && move_addr_o[15:0] == $past(cur_tbl_ptr, 2) - `MCD_PTR_STEP)
        else $error("parallel move address wrong");
    chk_tbl_step: assert property (dec_valid_i && dec_tbl_mod_i == MCD_PM_DEC && !sfr_we_i
        |=> st.tbl_ptr[$past(dec_tbl_sel_i)] == $past(cur_tbl_ptr) - `MCD_PTR_STEP)
        else $error("table pointer decrement wrong");
    chk_tbl_window: assert property (!coproc_copy_insn_i |->
        tbl_eff >= `MCD_DPRAM_BASE && tbl_eff <= `MCD_DPRAM_LAST)
        else $error("table access outside dual-port ram");
    chk_sat_value: assert property ($rose(st.sl) && !$past(clr_saturated_i) |->
        st.acc == `MCD_SAT_POS || st.acc == `MCD_SAT_NEG)
        else $error("saturation flag set without saturated value");
    chk_sticky_hold: assert property (st.sv && !clr_sticky_overflow_i |=> st.sv)
        else $error("sticky overflow flag dropped");
    chk_sl_hold: assert property (st.sl && !clr_saturated_i |=> st.sl)
        else $error("saturated flag dropped");
    chk_ext_flag: assert property (ext_flag_o == !((&st.acc[`MCD_ACC_MSB:`MCD_SAT_LSB])
        || !(|st.acc[`MCD_ACC_MSB:`MCD_SAT_LSB])))
        else $error("extension flag disagrees with accumulator");
    chk_limit_pos: assert property (st.ext && !st.acc[`MCD_ACC_MSB]
        |-> limited_acc_read_o == `MCD_LIM_POS)
        else $error("positive limit value wrong");
    chk_round_clear: assert property (dec_valid_i && dec_wr_acc_i && dec_round_i
        && !saturate_enable_i ##1 !saturate_enable_i |=> acc_low_word_o == 16'h0000)
        else $error("rounding left low word set");

    cov_move: cover property (move_wr_en_o);
    cov_saturate: cover property (st.e_valid && st.e_wr_acc && sat);
    cov_overflow40: cover property (st.e_valid && st.e_wr_acc && ovf40);
    cov_round: cover property (st.e_valid && st.e_wr_acc && st.e_round);
endmodule : mcd_datapath

// ===== hw/mcd_params.svh
// constants for the multiply-accumulate coprocessor datapath
`ifndef MCD_PARAMS_SVH
`define MCD_PARAMS_SVH
// accumulator geometry
`define MCD_ACC_MSB     39
`define MCD_SAT_LSB     31
`define MCD_ACC_RESET   40'h00_0000_0000
// adder constants
`define MCD_ROUND_CONST 40'h00_0000_8000
`define MCD_SAT_POS     40'h00_7FFF_FFFF
`define MCD_SAT_NEG     40'hFF_8000_0000
// limiter outputs
`define MCD_LIM_POS     16'h7FFF
`define MCD_LIM_NEG     16'h8000
// pointer step and internal dual-port ram window
`define MCD_PTR_STEP    16'h0002
`define MCD_DPRAM_BASE  16'hFA00
`define MCD_DPRAM_LAST  16'hFDFF
`define MCD_DPRAM_AW    10
// status word bit positions
`define MCD_MSW_E       12
`define MCD_MSW_SV      11
`define MCD_MSW_SL      10
`endif

// ===== hw/mcd_pkg.sv
// types of the multiply-accumulate coprocessor datapath
package mcd_pkg;
    // pointer post-modification
    typedef enum logic [4:0] {
        MCD_PM_KEEP = 5'h01,
        MCD_PM_INC  = 5'h02,
        MCD_PM_DEC  = 5'h04,
        MCD_PM_ADDQ = 5'h08,
        MCD_PM_SUBQ = 5'h10
    } mcd_pmod_t;
    // adder A source
    typedef enum logic [3:0] {
        MCD_A_ZERO  = 4'h1,
        MCD_A_ROUND = 4'h2,
        MCD_A_PROD  = 4'h4,
        MCD_A_CAT   = 4'h8
    } mcd_asel_t;
    // software-writable pointer and offset registers
    typedef enum logic [2:0] {
        MCD_SFR_TPA = 3'h0,
        MCD_SFR_TPB = 3'h1,
        MCD_SFR_TOA = 3'h2,
        MCD_SFR_TOB = 3'h3,
        MCD_SFR_GOA = 3'h4,
        MCD_SFR_GOB = 3'h5
    } mcd_sfr_t;
    // complete state of the datapath
    typedef struct packed {
        logic [1:0][15:0] tbl_ptr;
        logic [1:0][15:0] tbl_off;
        logic [1:0][15:0] gpr_off;
        logic             e_valid;
        logic             e_wr_acc;
        mcd_asel_t        e_asel;
        logic             e_b_acc;
        logic             e_b_inv;
        logic             e_b_shl;
        logic             e_cat_shl;
        logic             e_round;
        logic             e_sa;
        logic             e_sb;
        logic [15:0]      e_opa;
        logic [15:0]      e_opb;
        logic             e_gpr_we;
        logic [3:0]       e_gpr_idx;
        logic [15:0]      e_gpr_val;
        logic             e_move;
        logic [15:0]      e_move_addr;
        logic             w_move;
        logic [15:0]      w_move_addr;
        logic [15:0]      w_move_data;
        logic [39:0]      acc;
        logic             ext;
        logic             sv;
        logic             sl;
    } mcd_state_t;
endpackage : mcd_pkg

// ===== verification/mcd_host_model.sv
// host register bank and operand memory seen by the coprocessor
`timescale 1ns/10ps
module mcd_host_model (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // general register bank
    input  wire logic [3:0]  gpr_idx_i,
    output logic      [15:0] gpr_ptr_o,
    input  wire logic        gpr_wr_en_i,
    input  wire logic [3:0]  gpr_wr_idx_i,
    input  wire logic [15:0] gpr_wr_data_i,
    // operand fetch
    input  wire logic [23:0] tbl_addr_i,
    input  wire logic [23:0] gpr_addr_i,
    output logic      [15:0] bus_a_o,
    output logic      [15:0] bus_b_o
);
    logic [15:0] bank [16];
    // memory is a hash of the address, so a wrong address shows as wrong data
    assign bus_a_o   = tbl_addr_i[15:0] * 16'h9E37 + 16'h1F3B;
    assign bus_b_o   = gpr_addr_i[15:0] * 16'h9E37 + 16'h1F3B;
    assign gpr_ptr_o = bank[gpr_idx_i];
    // pointer write-back lands at the end of execute
    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < 16; i++) begin
            if (rst_i)
                bank[i] <= 16'(i) * 16'h1000 + 16'h0100;
            else if (gpr_wr_en_i && gpr_wr_idx_i == 4'(i))
                bank[i] <= gpr_wr_data_i;
        end
    end
endmodule : mcd_host_model

// ===== verification/tb.sv
// self-checking bench of the coprocessor datapath
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
    import mcd_pkg::*;
    // ports
    logic ref_clk_i = 0, rst_i = 1, dec_valid_i = 0, mac_with_move_insn_i = 0;
    logic coproc_copy_insn_i = 0, dec_tbl_sel_i = 0, dec_tbl_off_sel_i = 0, dec_gpr_off_sel_i = 0;
    logic dec_wr_acc_i = 0, dec_b_acc_i = 0, dec_b_inv_i = 0, dec_b_shl_i = 0, dec_cat_shl_i = 0;
    logic dec_round_i = 0, dec_signed_a_i = 0, dec_signed_b_i = 0, sfr_we_i = 0;
    logic fraction_shift_enable_i = 0, saturate_enable_i = 0;
    logic clr_sticky_overflow_i = 0, clr_saturated_i = 0;
    logic [3:0]  dec_gpr_idx_i = 0, gpr_wr_idx_o;
    logic [7:0]  data_page_i = 8'h3C, acc_ext_byte_o;
    logic [15:0] sfr_wdata_i = 0, dec_gpr_ptr_i, operand_bus_a_i, operand_bus_b_i;
    mcd_pmod_t   dec_tbl_mod_i = MCD_PM_KEEP, dec_gpr_mod_i = MCD_PM_KEEP;
    mcd_asel_t   dec_asel_i = MCD_A_ZERO;
    mcd_sfr_t    sfr_sel_i = MCD_SFR_TPA;
    logic gpr_wr_en_o, move_wr_en_o, ext_flag_o, sticky_overflow_flag_o, saturated_flag_o;
    logic [15:0] gpr_wr_data_o, move_data_o, acc_high_word_o, acc_low_word_o;
    logic [15:0] mac_status_word_o, limited_acc_read_o, table_pointer_a_o, table_pointer_b_o;
    logic [23:0] tbl_addr_o, gpr_addr_o, move_addr_o;
    // bench copy of the architectural state
    logic [15:0] tp [2], to [2], go [2], gb [16];
    logic [39:0] acc = 0;
    logic        sv = 0, sl = 0;
    int          error_cnt = 0, n_compared = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    mcd_datapath dut (.ref_clk_i, .rst_i, .dec_valid_i, .mac_with_move_insn_i,
        .coproc_copy_insn_i, .dec_tbl_sel_i, .dec_tbl_mod_i, .dec_tbl_off_sel_i, .dec_gpr_idx_i,
        .dec_gpr_ptr_i, .dec_gpr_mod_i, .dec_gpr_off_sel_i, .dec_wr_acc_i, .dec_asel_i,
        .dec_b_acc_i, .dec_b_inv_i, .dec_b_shl_i, .dec_cat_shl_i, .dec_round_i, .dec_signed_a_i,
        .dec_signed_b_i, .data_page_i, .tbl_addr_o, .gpr_addr_o, .operand_bus_a_i,
        .operand_bus_b_i, .sfr_we_i, .sfr_sel_i, .sfr_wdata_i, .fraction_shift_enable_i,
        .saturate_enable_i, .clr_sticky_overflow_i, .clr_saturated_i, .gpr_wr_en_o,
        .gpr_wr_idx_o, .gpr_wr_data_o, .move_wr_en_o, .move_addr_o, .move_data_o,
        .acc_high_word_o, .acc_low_word_o, .acc_ext_byte_o, .mac_status_word_o, .ext_flag_o,
        .sticky_overflow_flag_o, .saturated_flag_o, .limited_acc_read_o, .table_pointer_a_o,
        .table_pointer_b_o);
    mcd_host_model host (.ref_clk_i, .rst_i, .gpr_idx_i(dec_gpr_idx_i),
        .gpr_ptr_o(dec_gpr_ptr_i), .gpr_wr_en_i(gpr_wr_en_o), .gpr_wr_idx_i(gpr_wr_idx_o),
        .gpr_wr_data_i(gpr_wr_data_o), .tbl_addr_i(tbl_addr_o), .gpr_addr_i(gpr_addr_o),
        .bus_a_o(operand_bus_a_i), .bus_b_o(operand_bus_b_i));

    // new pointer (bk=0) or reversed move address (bk=1)
    function automatic logic [15:0] pm(logic [15:0] p, q, mcd_pmod_t m, logic bk);
        logic [15:0] d;
        d = (m == MCD_PM_INC || m == MCD_PM_DEC) ? 16'h0002 : q;
        if (m == MCD_PM_KEEP) return p;
        return ((m == MCD_PM_INC || m == MCD_PM_ADDQ) ^ bk) ? p + d : p - d;
    endfunction : pm

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    task automatic sfr(input int k, input logic [15:0] v);
        @(posedge ref_clk_i);
        sfr_we_i <= 1;
        sfr_sel_i <= mcd_sfr_t'(k);
        sfr_wdata_i <= v;
        @(posedge ref_clk_i);
        sfr_we_i <= 0;
        if (k < 2) tp[k] = v; else if (k < 4) to[k-2] = v; else go[k-4] = v;
    endtask : sfr

    // one instruction, spaced three cycles so no register read follows an update
    task automatic op(input mcd_pmod_t tm, gm, input mcd_asel_t as, input logic mv);
        logic ts, os, qs, cp, ba, bi, bs, cs, sa, sb, fs, se, wa, e;
        logic [3:0] g;
        logic [15:0] p, a, b, ta;
        logic signed [33:0] pr;
        logic [39:0] av, bv, r;
        logic [40:0] s;
        {ts, os, qs, cp, ba, bi, bs, cs, sa, sb, fs, se, wa} = 13'($urandom);
        g = 4'($urandom);
        cp = cp & ~mv;
        p = tp[ts];
        ta = (cp || (p >= 16'hFA00 && p <= 16'hFDFF)) ? p : 16'hFA00 + {6'h00, p[9:0]};
        a = ta * 16'h9E37 + 16'h1F3B;
        b = gb[g] * 16'h9E37 + 16'h1F3B;
        @(posedge ref_clk_i);
        {dec_valid_i, mac_with_move_insn_i, coproc_copy_insn_i, dec_tbl_sel_i, dec_tbl_off_sel_i,
         dec_gpr_off_sel_i, dec_wr_acc_i, dec_b_acc_i, dec_b_inv_i, dec_b_shl_i, dec_cat_shl_i,
         dec_round_i, dec_signed_a_i, dec_signed_b_i, fraction_shift_enable_i, saturate_enable_i}
            <= {1'b1, mv, cp, ts, os, qs, wa, ba, bi, bs, cs, as == MCD_A_ROUND, sa, sb, fs, se};
        dec_gpr_idx_i <= g;
        dec_tbl_mod_i <= tm;
        dec_gpr_mod_i <= gm;
        dec_asel_i <= as;
        #1;
        `CHK("tbl_addr", ta, tbl_addr_o[15:0])
        `CHK("gpr_addr", {data_page_i, gb[g]}, gpr_addr_o)
        @(posedge ref_clk_i);
        dec_valid_i <= 0;
        mac_with_move_insn_i <= 0;
        #1;
        `CHK("acc_hold", acc, {acc_ext_byte_o, acc_high_word_o, acc_low_word_o})
        `CHK("gpr_we", gm != MCD_PM_KEEP, gpr_wr_en_o)
        if (gm != MCD_PM_KEEP) begin
            gb[g] = pm(gb[g], go[qs], gm, 0);
            `CHK("gpr_wd", {g, gb[g]}, {gpr_wr_idx_o, gpr_wr_data_o})
        end
        tp[ts] = pm(p, to[os], tm, 0);
        `CHK("tptr", {tp[0], tp[1]}, {table_pointer_a_o, table_pointer_b_o})
        // expected arithmetic: product, concatenation, round or zero into A
        pr = $signed({sa & a[15], a}) * $signed({sb & b[15], b});
        av = as == MCD_A_PROD ? {{6{pr[33]}}, pr} << fs : as == MCD_A_CAT ?
            {{8{a[15]}}, a, b} << cs : as == MCD_A_ROUND ? 40'h00_0000_8000 : 40'h0;
        bv = ba ? acc << bs : 40'h0;
        bv = bi ? -bv : bv;
        s = {av[39], av} + {bv[39], bv};
        r = s[39:0];
        e = (s[40] ^ s[39]) | ~(&r[39:31] | ~|r[39:31]);
        if (wa) begin
            sv |= s[40] ^ s[39];
            sl |= se & e;
            r = (se & e) ? (s[40] ? 40'hFF_8000_0000 : 40'h00_7FFF_FFFF) : r;
            if (as == MCD_A_ROUND && !(se & e)) r[15:0] = 16'h0000;
            acc = r;
        end
        @(posedge ref_clk_i);
        #1;
        `CHK("move_en", mv, move_wr_en_o)
        if (mv) `CHK("move", {pm(p, to[os], tm, 1) & 16'h03FF, a},
            {6'h00, move_addr_o[9:0], move_data_o})
        e = ~(&acc[39:31] | ~|acc[39:31]);
        `CHK("acc", acc, {acc_ext_byte_o, acc_high_word_o, acc_low_word_o})
        `CHK("msw", {3'h0, e, sv, sl, 2'h0, acc[39:32]}, mac_status_word_o)
        `CHK("flags", {e, sv, sl}, {ext_flag_o, sticky_overflow_flag_o, saturated_flag_o})
        `CHK("limit", e ? (acc[39] ? 16'h8000 : 16'h7FFF) : acc[31:16],
            limited_acc_read_o)
    endtask : op

    // sticky flags drop only on an explicit clear
    task automatic clr;
        @(posedge ref_clk_i);
        {clr_sticky_overflow_i, clr_saturated_i} <= 2'b11;
        @(posedge ref_clk_i);
        {clr_sticky_overflow_i, clr_saturated_i} <= 2'b00;
        {sv, sl} = 2'b00;
        #1;
        `CHK("clear", 2'b00, {sticky_overflow_flag_o, saturated_flag_o})
    endtask : clr

    // hang guard
    initial begin
        #200000;
        error_cnt++;
        complete_run;
    end

    initial begin
        void'($urandom(32'h1781));
        for (int i = 0; i < 16; i++) gb[i] = 16'(i) * 16'h1000 + 16'h0100;
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 0;
        #1;
        `CHK("rst", 32'h0, {mac_status_word_o, limited_acc_read_o})
        for (int k = 0; k < 6; k++) sfr(k, 16'($urandom) & (k < 2 ? 16'hFFFE : 16'h00FE));
        // every modification kind and every A source, with a move
        for (int m = 0; m < 5; m++) op(mcd_pmod_t'(5'h01 << m), mcd_pmod_t'(5'h01 << m),
            mcd_asel_t'(4'h1 << (m % 4)), 1'b1);
        // random stream with occasional sticky clears
        for (int i = 0; i < 400; i++) begin
            op(mcd_pmod_t'(5'h01 << ($urandom % 5)), mcd_pmod_t'(5'h01 << ($urandom % 5)),
                mcd_asel_t'(4'h1 << ($urandom % 4)), 1'($urandom));
            if (i % 37 == 36) clr;
        end
        complete_run;
    end
endmodule : tb
